// *** include/pulse_measure_pkg.sv ***
// Purpose: Shared constants and types for the pulse period/width measurement channel
// Assumes: AXI4-Lite register access with 32-bit data, one aligned word per register
// Notes: All fields live in the low 16 bits of their register

package pulse_measure_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [4:0] START_OFS = 5'h00;
    localparam logic [4:0] MODE_OFS = 5'h04;
    localparam logic [4:0] RELOAD_OFS = 5'h08;
    localparam logic [4:0] FLAG_OFS = 5'h0c;
    localparam logic [4:0] IRQ_STAT_OFS = 5'h10;
    localparam logic [4:0] IRQ_MASK_OFS = 5'h14;
    localparam logic [4:0] COUNT_OFS = 5'h18;

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int START_BIT = 0;
    localparam int MODE_WIDTH_BIT = 0;
    localparam int MODE_FALL_BIT = 1;
    localparam int FLAG_OVF_BIT = 0;
    localparam int FLAG_FIRST_BIT = 1;
    localparam int IRQ_MEAS_BIT = 0;
    localparam int IRQ_OVF_BIT = 1;

    ////////////////////////////////////////////////////////////////////////////////
    // Widths and reset values
    localparam int COUNT_W = 16;
    localparam logic [COUNT_W-1:0] COUNT_MAX = 16'hffff;
    localparam logic OVF_RESET = 1'h1;
    localparam logic [1:0] IRQ_RESET = 2'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    ////////////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic fall_sel;   // Period mode: measure falling to falling
        logic width_sel;  // Pulse width mode: every edge counts
    } mode_t;

    typedef struct packed {
        logic rise;
        logic fall;
    } edge_t;

endpackage : pulse_measure_pkg

// *** src/pin_edge_sync.sv ***
// Purpose: Two-stage synchroniser for the measured pin with edge detection
// Assumes: Pin is asynchronous to aclk
// Notes: First stage is read only by the second stage

module pin_edge_sync
    import pulse_measure_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pin_in,
    output pulse_measure_pkg::edge_t edges
);
    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    // Two flip-flop synchroniser and one history stage
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta_reg <= 1'h0;
            sync_reg <= 1'h0;
            last_reg <= 1'h0;
        end
        else
        begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    // Edge pulses from synchronised samples
    assign edges.rise = sync_reg & ~last_reg;
    assign edges.fall = ~sync_reg & last_reg;

endmodule : pin_edge_sync

// *** src/pulse_period_width_measure.sv ***
// Purpose: Timer channel measuring pulse period or pulse width of an external input
// Assumes: Counter advances on every aclk while counting; AXI4-Lite slave for software
// Notes: Overflow flag is cleared only by a qualified mode register write
// Summary of operation
// - Mode type change while counting raises request
// - First edge after start loads meaningless count
// - No request on first edge after start
// - Aged overflow cleared by mode register write
// - Reset overflow unknown; start then write clears
//
// The AXI4-Lite register port and the address map are this design's own decisions.

module pulse_period_width_measure
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pulse_in,
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq
);
    import pulse_measure_pkg::*;
    edge_t edges;
    logic aw_hold_reg;
    logic [4:0] awaddr_reg;
    logic w_hold_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic wr_fire;
    logic wr_low;
    logic mode_wr;
    logic start_reg;
    mode_t mode_reg;
    logic [COUNT_W-1:0] count_reg;
    logic [COUNT_W-1:0] reload_reg;
    logic first_reg;
    logic ovf_reg;
    logic ovf_aged_reg;
    logic [1:0] irq_stat_reg;
    logic [1:0] irq_mask_reg;
    logic eff_edge;
    logic wrap;
    logic type_change;
    logic meas_set;
    logic [1:0] irq_set;
    logic [31:0] rd_next;
    logic rd_ok;

    ////////////////////////////////////////////////////////////////////////////////
    // Input pin synchroniser
    pin_edge_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in(pulse_in),
        .edges(edges)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write path: address and data taken in either order
    assign s_axi_awready = ~aw_hold_reg & ~s_axi_bvalid;
    assign s_axi_wready = ~w_hold_reg & ~s_axi_bvalid;
    assign wr_fire = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
    assign wr_low = wr_fire & wstrb_reg[0];
    assign mode_wr = wr_low & (awaddr_reg == MODE_OFS);
    // Write address and data holding
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_reg <= 1'h0;
            w_hold_reg <= 1'h0;
            awaddr_reg <= 5'h00;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_reg <= 1'h1;
                awaddr_reg <= s_axi_awaddr;
            end
            else if (wr_fire)
            begin
                aw_hold_reg <= 1'h0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_reg <= 1'h1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            else if (wr_fire)
            begin
                w_hold_reg <= 1'h0;
            end
        end
    end

    // Write response; unmapped or read-only offsets answer SLVERR
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'h0;
            s_axi_bresp <= RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'h1;
            s_axi_bresp <= (awaddr_reg == START_OFS || awaddr_reg == MODE_OFS || awaddr_reg == IRQ_STAT_OFS
                || awaddr_reg == IRQ_MASK_OFS) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Control registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            start_reg <= 1'h0;
            mode_reg <= '0;
            irq_mask_reg <= IRQ_RESET;
        end
        else if (wr_low)
        begin
            if (awaddr_reg == START_OFS)
                start_reg <= wdata_reg[START_BIT];
            if (awaddr_reg == MODE_OFS)
            begin
                mode_reg.width_sel <= wdata_reg[MODE_WIDTH_BIT];
                mode_reg.fall_sel <= wdata_reg[MODE_FALL_BIT];
            end
            if (awaddr_reg == IRQ_MASK_OFS)
                irq_mask_reg <= wdata_reg[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Measurement counter and reload capture
    assign eff_edge = mode_reg.width_sel ? (edges.rise | edges.fall)
        : (mode_reg.fall_sel ? edges.fall : edges.rise);
    assign wrap = start_reg & ~eff_edge & (count_reg == COUNT_MAX);
    assign type_change = mode_wr & start_reg & (wdata_reg[MODE_WIDTH_BIT] != mode_reg.width_sel);
    assign meas_set = (start_reg & eff_edge & ~first_reg) | type_change;
    // Count, capture on each effective edge
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            count_reg <= '0;
            reload_reg <= '0;
            first_reg <= 1'h1;
        end
        else if (!start_reg)
        begin
            count_reg <= '0;
            first_reg <= 1'h1;
        end
        else if (eff_edge)
        begin
            reload_reg <= count_reg;
            count_reg <= '0;
            first_reg <= 1'h0;
        end
        else
        begin
            count_reg <= count_reg + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Overflow flag: set on wrap, cleared by a mode write once a count cycle passed
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ovf_reg <= OVF_RESET;
            ovf_aged_reg <= 1'h0;
        end
        else
        begin
            if (wrap)
                ovf_reg <= 1'h1;
            else if (mode_wr && ovf_aged_reg)
                ovf_reg <= 1'h0;
            if (wrap || !ovf_reg)
                ovf_aged_reg <= 1'h0;
            else if (start_reg)
                ovf_aged_reg <= 1'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt status, write one to clear; set wins
    assign irq_set = {wrap, meas_set};
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_stat_reg <= IRQ_RESET;
        end
        else
        begin
            irq_stat_reg <= (irq_stat_reg & ~((wr_low && awaddr_reg == IRQ_STAT_OFS) ? wdata_reg[1:0] : 2'h0))
                | irq_set;
        end
    end
    // Level interrupt while an unmasked status bit is set
    assign irq = |(irq_stat_reg & irq_mask_reg);
    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read path
    assign s_axi_arready = ~s_axi_rvalid;
    // Read data selection
    always_comb
    begin
        rd_next = 32'h0000_0000;
        rd_ok = 1'h1;
        unique case (s_axi_araddr)
            START_OFS: rd_next[START_BIT] = start_reg;
            MODE_OFS: rd_next[1:0] = mode_reg;
            RELOAD_OFS: rd_next[COUNT_W-1:0] = reload_reg;
            FLAG_OFS: rd_next[1:0] = {first_reg, ovf_reg};
            IRQ_STAT_OFS: rd_next[1:0] = irq_stat_reg;
            IRQ_MASK_OFS: rd_next[1:0] = irq_mask_reg;
            COUNT_OFS: rd_next[COUNT_W-1:0] = count_reg;
            default: rd_ok = 1'h0;
        endcase
    end
    // Read data register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'h0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'h1;
            s_axi_rdata <= rd_next;
            s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_type_change_irq;
        type_change |=> irq_stat_reg[IRQ_MEAS_BIT];
    endproperty
    a_type_change_irq: assert property (p_type_change_irq) else $error("mode type change left no request");
    property p_first_capture;
        start_reg && first_reg && eff_edge |=> reload_reg == $past(count_reg) && !first_reg && count_reg == '0;
    endproperty
    a_first_capture: assert property (p_first_capture) else $error("first edge capture wrong");
    property p_first_no_irq;
        start_reg && first_reg && eff_edge && !type_change && !irq_stat_reg[IRQ_MEAS_BIT]
            |=> !irq_stat_reg[IRQ_MEAS_BIT];
    endproperty
    a_first_no_irq: assert property (p_first_no_irq) else $error("request raised on first edge");
    property p_ovf_clear;
        mode_wr && ovf_aged_reg && !wrap |=> !ovf_reg ##1 !ovf_aged_reg;
    endproperty
    a_ovf_clear: assert property (p_ovf_clear) else $error("aged overflow not cleared by mode write");
    property p_start_ages_ovf;
        $rose(start_reg) && ovf_reg && !mode_wr |=> ovf_aged_reg;
    endproperty
    a_start_ages_ovf: assert property (p_start_ages_ovf) else $error("overflow not armed after start");
    property p_wrap_ovf;
        wrap |=> ovf_reg && count_reg == '0 && irq_stat_reg[IRQ_OVF_BIT] && !ovf_aged_reg;
    endproperty
    a_wrap_ovf: assert property (p_wrap_ovf) else $error("wrap did not set overflow");
endmodule : pulse_period_width_measure

// *** bench/pulse_source.sv ***
// Purpose: Model of the external pulse on the measured pin
// Assumes: Level changes on rising aclk edges, so edge spacing is exact
// Notes: Idle low while disabled; a disable may make one falling edge

module pulse_source
(
    input wire logic aclk,
    input wire logic en,
    input wire logic [15:0] half,
    output logic pulse_out
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [15:0] cnt_reg = 16'h0001;

    ////////////////////////////////////////
    // Toggle every half period while enabled
    always @(posedge aclk)
    begin
        if (!en)
        begin
            pulse_out <= 1'b0;
            cnt_reg <= 16'h0001;
        end
        else if (cnt_reg >= half)
        begin
            pulse_out <= ~pulse_out;
            cnt_reg <= 16'h0001;
        end
        else
            cnt_reg <= cnt_reg + 16'h0001;
    end
endmodule : pulse_source

// *** bench/tb_pulse_period_width_measure.sv ***
// Purpose: Self-checking bench for the pulse measurement channel
// Assumes: Handshakes judged at the falling edge before the taking edge
// Notes: Fixed seed; random periods, mode and overflow corners by hand

module tb_pulse_period_width_measure;
    timeunit 1ns;
    timeprecision 100ps;
    import pulse_measure_pkg::*;

    logic aclk = 1'b0, aresetn = 1'b0, src_en = 1'b0;
    logic [15:0] src_half = 16'h0010;
    logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, pulse_in;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    int n_errors = 0, cmp_count = 0;
    logic [1:0] modes [3] = '{2'h0, 2'h2, 2'h1};

    always #2 aclk = ~aclk;

    pulse_source src (.aclk(aclk), .en(src_en), .half(src_half), .pulse_out(pulse_in));

    pulse_period_width_measure dut (.aclk, .aresetn, .pulse_in, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);

    ////////////////////////////////////////
    // Comparison, verdict and bus tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Capture of the second effective edge: one less than the edge spacing
    function automatic logic [31:0] exp_capture(input logic [1:0] m, input int h);
        return 32'((m[MODE_WIDTH_BIT] ? h : 2 * h) - 1);
    endfunction : exp_capture

    task automatic wrap_up();
        $display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up

    task automatic timed_out(input string what);
        n_errors++;
        $display("ERROR %s expected answer seen timeout", what);
        wrap_up();
    endtask : timed_out

    task automatic axi_write(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
        bit aw_go, w_go, b_go;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 100; n++)
        begin
            @(negedge aclk);
            aw_go = s_axi_awvalid && s_axi_awready;
            w_go = s_axi_wvalid && s_axi_wready;
            b_go = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (aw_go)
                s_axi_awvalid <= 1'b0;
            if (w_go)
                s_axi_wvalid <= 1'b0;
            if (b_go)
            begin
                s_axi_bready <= 1'b0;
                return;
            end
        end
        timed_out("write");
    endtask : axi_write

    task automatic axi_read(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
        bit ar_go, r_go;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 100; n++)
        begin
            @(negedge aclk);
            ar_go = s_axi_arvalid && s_axi_arready;
            r_go = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ar_go)
                s_axi_arvalid <= 1'b0;
            if (r_go)
            begin
                s_axi_rready <= 1'b0;
                return;
            end
        end
        timed_out("read");
    endtask : axi_read

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_write(a, d, r);
        check("write resp", 32'(r), 32'(RESP_OKAY));
    endtask : wr

    task automatic rd(input logic [4:0] a, output logic [31:0] d);
        logic [1:0] r;
        axi_read(a, d, r);
        check("read resp", 32'(r), 32'(RESP_OKAY));
    endtask : rd

    // Poll one register bit until it reaches a level
    task automatic wait_bit(input logic [4:0] a, input int b, input logic v);
        logic [31:0] d;
        for (int n = 0; n < 400; n++)
        begin
            rd(a, d);
            if (d[b] === v)
                return;
        end
        timed_out("poll");
    endtask : wait_bit

    ////////////////////////////////////////
    // Main sequence
    initial
    begin
        logic [31:0] d;
        logic [1:0] r;
        int half;
        void'($urandom(67));
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd(FLAG_OFS, d);
        check("flags after reset", d, {30'h0, 1'b1, OVF_RESET});
        check("irq after reset", 32'(irq), 32'h0);
        axi_read(5'h1c, d, r);
        check("unmapped resp", 32'(r), 32'(RESP_SLVERR));
        check("unmapped data", d, 32'h0);
        axi_write(RELOAD_OFS, 32'h1234, r);
        check("read-only resp", 32'(r), 32'(RESP_SLVERR));
        // Start, unmask, then a mode write clears the undefined overflow
        wr(START_OFS, 32'h1);
        rd(START_OFS, d);
        check("start readback", d, 32'h1);
        wr(IRQ_MASK_OFS, 32'h3);
        rd(IRQ_MASK_OFS, d);
        check("mask readback", d, 32'h3);
        wr(MODE_OFS, 32'h0);
        rd(FLAG_OFS, d);
        check("overflow after start", 32'(d[FLAG_OVF_BIT]), 32'h0);
        rd(IRQ_STAT_OFS, d);
        check("stat same mode", d, 32'h0);
        // Each edge mode: first edge raises no request, second one counts
        foreach (modes[i])
        begin
            half = 20 + 2 * ($urandom % 30);
            wr(START_OFS, 32'h0);
            src_en <= 1'b0;
            wr(MODE_OFS, 32'(modes[i]));
            rd(MODE_OFS, d);
            check("mode readback", d, 32'(modes[i]));
            wr(START_OFS, 32'h1);
            wr(IRQ_STAT_OFS, 32'h3);
            src_half <= 16'(half);
            src_en <= 1'b1;
            wait_bit(FLAG_OFS, FLAG_FIRST_BIT, 1'b0);
            rd(IRQ_STAT_OFS, d);
            check("request on first edge", 32'(d[IRQ_MEAS_BIT]), 32'h0);
            wait_bit(IRQ_STAT_OFS, IRQ_MEAS_BIT, 1'b1);
            rd(RELOAD_OFS, d);
            check("captured count", d, exp_capture(modes[i], half));
        end
        // Mode type change while counting raises the request
        src_en <= 1'b0;
        repeat (8) @(posedge aclk);
        wr(IRQ_STAT_OFS, 32'h3);
        wr(MODE_OFS, 32'h0);
        rd(IRQ_STAT_OFS, d);
        check("stat after type change", d, 32'h1);
        check("irq unmasked", 32'(irq), 32'h1);
        wr(IRQ_MASK_OFS, 32'h0);
        check("irq masked", 32'(irq), 32'h0);
        wr(IRQ_STAT_OFS, 32'h1);
        rd(IRQ_STAT_OFS, d);
        check("stat cleared", d, 32'h0);
        // No edges for a whole counter span: wrap sets the flag
        repeat (32'(COUNT_MAX) + 64) @(posedge aclk);
        rd(FLAG_OFS, d);
        check("overflow after wrap", 32'(d[FLAG_OVF_BIT]), 32'h1);
        rd(IRQ_STAT_OFS, d);
        check("wrap request", 32'(d[IRQ_OVF_BIT]), 32'h1);
        wr(IRQ_MASK_OFS, 32'h2);
        check("irq on wrap", 32'(irq), 32'h1);
        wr(MODE_OFS, 32'h0);
        rd(FLAG_OFS, d);
        check("overflow after mode write", 32'(d[FLAG_OVF_BIT]), 32'h0);
        wr(IRQ_STAT_OFS, 32'h2);
        check("irq after clear", 32'(irq), 32'h0);
        // Reset in mid-run brings back the reset state
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(FLAG_OFS, d);
        check("flags after second reset", d, {30'h0, 1'b1, OVF_RESET});
        rd(START_OFS, d);
        check("start after second reset", d, 32'h0);
        rd(IRQ_STAT_OFS, d);
        check("stat after second reset", d, 32'h0);
        check("irq after second reset", 32'(irq), 32'h0);
        wrap_up();
    end
endmodule : tb_pulse_period_width_measure
